// ===== sec_ctrl.sv
// serial rom controller: address auto-load, host commands and serial link engine
`timescale 1ns/10ps
module sec_ctrl
    import sec_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic link_clk,
    // host command side
    input wire logic soft_reset,
    input wire logic cmd_go,
    input wire logic [2:0] command_code_field,
    input wire logic [6:0] command_address_field,
    input wire logic data_wr_en,
    input wire logic [7:0] data_wr,
    input wire logic timeout_clr,
    input wire logic iface_en,
    input wire logic [1:0] gpio_out,
    // host status
    output logic command_busy_bit,
    output logic response_timeout_bit,
    output logic reload_success_bit,
    output logic [7:0] serial_rom_data_reg,
    output logic [47:0] station_address,
    // rom pins
    output logic serial_rom_clock_pin,
    output logic serial_rom_cs,
    output logic serial_rom_data_pin_o,
    output logic serial_rom_data_pin_oe_n,
    input wire logic serial_rom_data_pin_i
);
    // ------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------
    sec_core_e state_reg;
    sec_req_s req_reg;
    logic busy_reg, to_reg, loaded_reg, load_reg, soft_pend_reg, abort_reg, req_tgl_reg;
    logic [2:0] idx_reg;
    logic [7:0] data_reg;
    logic [47:0] sta_reg;
    logic [TMR_W-1:0] timer_reg;
    logic done_s1, done_s2, done_s3;
    logic [7:0] rdata_l;
    logic done_tgl_l;

    wire done_p = done_s2 ^ done_s3;
    wire tmo = timer_reg == TMR_W'(TIMEOUT_CYCLES - 1);
    wire in_idle = state_reg == ST_IDLE;
    wire start_load = in_idle && soft_pend_reg;
    wire host_go = in_idle && !soft_pend_reg && cmd_go;
    wire go_load = start_load || (host_go && command_code_field == CMD_RELOAD);
    wire got = state_reg == ST_WAIT && done_p;
    wire sig_bad = load_reg && idx_reg == 3'h0 && rdata_l != SIG_BYTE;
    wire load_last = load_reg && idx_reg == MAC_BYTES;
    wire [5:0] sta_pos = {idx_reg - 3'h1, 3'h0};
    wire to_set = state_reg == ST_DRAIN && done_p;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
        end else begin
            done_s1 <= done_tgl_l;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
        end
    end

    // hardware set wins over software clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) to_reg <= 1'b0;
        else if (to_set) to_reg <= 1'b1;
        else if (timeout_clr) to_reg <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            req_reg <= '0;
            busy_reg <= 1'b1;
            loaded_reg <= 1'b0;
            load_reg <= 1'b0;
            soft_pend_reg <= 1'b1;
            abort_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
            idx_reg <= 3'h0;
            data_reg <= 8'h00;
            sta_reg <= 48'h0;
            timer_reg <= '0;
        end else begin
            if (soft_reset) soft_pend_reg <= 1'b1;
            if (data_wr_en && !busy_reg) data_reg <= data_wr;
            case (state_reg)
                ST_IDLE: begin
                    if (go_load) begin
                        soft_pend_reg <= soft_reset;
                        load_reg <= 1'b1;
                        loaded_reg <= 1'b0;
                        idx_reg <= 3'h0;
                        busy_reg <= 1'b1;
                        req_reg <= '{code: CMD_READ, addr: SIG_ADDR, data: 8'h00};
                        state_reg <= ST_ISSUE;
                    end else if (host_go) begin
                        busy_reg <= 1'b1;
                        req_reg <= '{code: command_code_field, addr: command_address_field, data: data_reg};
                        state_reg <= ST_ISSUE;
                    end else begin
                        busy_reg <= soft_pend_reg;
                    end
                end
                ST_ISSUE: begin
                    req_tgl_reg <= ~req_tgl_reg;
                    timer_reg <= '0;
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    timer_reg <= timer_reg + TMR_W'(1);
                    if (done_p) begin
                        if (!load_reg) begin
                            // read byte lands with busy clear
                            if (req_reg.code == CMD_READ) data_reg <= rdata_l;
                            busy_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else if (sig_bad) begin
                            load_reg <= 1'b0;
                            busy_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            if (idx_reg != 3'h0) sta_reg[sta_pos +: 8] <= rdata_l;
                            if (load_last) begin
                                loaded_reg <= 1'b1;
                                load_reg <= 1'b0;
                                busy_reg <= 1'b0;
                                state_reg <= ST_IDLE;
                            end else begin
                                idx_reg <= idx_reg + 3'h1;
                                req_reg.addr <= {4'h0, idx_reg + 3'h1};
                                state_reg <= ST_ISSUE;
                            end
                        end
                    end else if (tmo) begin
                        abort_reg <= 1'b1;
                        state_reg <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (done_p) begin
                        abort_reg <= 1'b0;
                        load_reg <= 1'b0;
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign command_busy_bit = busy_reg;
    assign response_timeout_bit = to_reg;
    assign reload_success_bit = loaded_reg;
    assign serial_rom_data_reg = data_reg;
    assign station_address = sta_reg;

    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    sec_link_e lstate_reg;
    sec_pins_s pins_reg, pins_next;
    logic req_s1, req_s2, req_s3, ab_s1, ab_s2, en_s1, en_s2, din_s1, din_s2, rd_reg, prog_reg, seen_reg;
    logic [1:0] gp_s1, gp_s2;
    logic [17:0] sreg;
    logic [4:0] nbits_reg, bitn_reg, edge_cnt;
    logic [2:0] ph_reg;

    wire req_p = req_s2 ^ req_s3;
    wire ph_end = ph_reg == PH_LAST;
    wire last_bit = bitn_reg == nbits_reg - 5'h1;
    wire rd_phase = rd_reg && bitn_reg >= BITS_HDR;
    wire abort_l = ab_s2 && lstate_reg != LS_IDLE;
    // the synchroniser still holds the wandering level of the deselected pin for a few cycles
    wire poll_live = ph_reg >= PH_SETTLE;
    wire poll_ok = lstate_reg == LS_POLL && poll_live && seen_reg && din_s2;

    // synchronisers; data pin only read after its second stage
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            {req_s1, req_s2, req_s3, ab_s1, ab_s2, en_s1, en_s2, din_s1, din_s2} <= '0;
            {gp_s1, gp_s2} <= 4'h0;
        end else begin
            {req_s1, req_s2, req_s3} <= {req_tgl_reg, req_s1, req_s2};
            {ab_s1, ab_s2} <= {abort_reg, ab_s1};
            {en_s1, en_s2} <= {iface_en, en_s1};
            {din_s1, din_s2} <= {serial_rom_data_pin_i, din_s1};
            {gp_s1, gp_s2} <= {gpio_out, gp_s1};
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lstate_reg <= LS_IDLE;
            sreg <= '0;
            nbits_reg <= BITS_SHORT;
            bitn_reg <= 5'h0;
            ph_reg <= 3'h0;
            rd_reg <= 1'b0;
            prog_reg <= 1'b0;
            seen_reg <= 1'b0;
            rdata_l <= 8'h00;
            done_tgl_l <= 1'b0;
        end else if (abort_l) begin
            lstate_reg <= LS_IDLE;
            done_tgl_l <= ~done_tgl_l;
        end else begin
            case (lstate_reg)
                LS_IDLE: begin
                    if (req_p) begin
                        sreg <= sec_frame(req_reg);
                        nbits_reg <= (req_reg.code == CMD_READ || req_reg.code == CMD_WRITE ||
                                      req_reg.code == CMD_WR_ALL) ? BITS_LONG : BITS_SHORT;
                        rd_reg <= req_reg.code == CMD_READ;
                        prog_reg <= sec_is_prog(req_reg.code);
                        bitn_reg <= 5'h0;
                        ph_reg <= 3'h0;
                        lstate_reg <= LS_SHIFT;
                    end
                end
                LS_SHIFT: begin
                    ph_reg <= ph_reg + 3'h1;
                    if (ph_end) begin
                        sreg <= {sreg[16:0], 1'b0};
                        if (rd_phase) rdata_l <= {rdata_l[6:0], din_s2};
                        bitn_reg <= bitn_reg + 5'h1;
                        if (last_bit) begin
                            lstate_reg <= prog_reg ? LS_GAP : LS_IDLE;
                            if (!prog_reg) done_tgl_l <= ~done_tgl_l;
                        end
                    end
                end
                LS_GAP: begin
                    ph_reg <= ph_reg + 3'h1;
                    seen_reg <= 1'b0;
                    if (ph_end) lstate_reg <= LS_POLL;
                end
                LS_POLL: begin
                    if (ph_reg != PH_LAST) ph_reg <= ph_reg + 3'h1;
                    if (poll_live && !din_s2) seen_reg <= 1'b1;
                    if (poll_ok) begin
                        lstate_reg <= LS_IDLE;
                        done_tgl_l <= ~done_tgl_l;
                    end
                end
                default: lstate_reg <= LS_IDLE;
            endcase
        end
    end

    // pins fall back to general outputs
    always_comb begin
        if (!en_s2) begin
            pins_next = '{sclk: gp_s2[0], cs: 1'b0, dout: gp_s2[1], oe_n: 1'b0};
        end else begin
            pins_next.sclk = lstate_reg == LS_SHIFT && ph_reg >= PH_RISE && ph_reg < PH_FALL;
            pins_next.cs = lstate_reg == LS_SHIFT || lstate_reg == LS_POLL;
            pins_next.dout = sreg[17];
            pins_next.oe_n = !(lstate_reg == LS_SHIFT && !rd_phase);
        end
    end

    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) pins_reg <= '{sclk: 1'b0, cs: 1'b0, dout: 1'b0, oe_n: 1'b1};
        else pins_reg <= pins_next;
    end

    // rising clock edges in the current select window, for checking only
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) edge_cnt <= 5'h0;
        else if (!pins_reg.cs) edge_cnt <= 5'h0;
        else if (pins_next.sclk && !pins_reg.sclk) edge_cnt <= edge_cnt + 5'h1;
    end

    assign serial_rom_clock_pin = pins_reg.sclk;
    assign serial_rom_cs = pins_reg.cs;
    assign serial_rom_data_pin_o = pins_reg.dout;
    assign serial_rom_data_pin_oe_n = pins_reg.oe_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence byte_arrive;
        got && load_reg && !sig_bad && idx_reg != 3'h0;
    endsequence
    busy_on_go_a: assert property (@(posedge core_clk) disable iff (!nrst) host_go |=> busy_reg)
        else $error("busy not set by go");
    timeout_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(to_reg) |-> !busy_reg && $past(state_reg) == ST_DRAIN) else $error("bad timeout");
    timer_cap_a: assert property (@(posedge core_clk) disable iff (!nrst)
        state_reg == ST_WAIT |-> timer_reg < TMR_W'(TIMEOUT_CYCLES)) else $error("wait past limit");
    read_result_a: assert property (@(posedge core_clk) disable iff (!nrst)
        got && !load_reg && req_reg.code == CMD_READ |=> !busy_reg && data_reg == $past(rdata_l))
        else $error("read byte missing");
    sig_miss_a: assert property (@(posedge core_clk) disable iff (!nrst)
        got && sig_bad |=> !loaded_reg && $stable(sta_reg) && !busy_reg) else $error("bad signature load");
    byte_order_a: assert property (@(posedge core_clk) disable iff (!nrst)
        byte_arrive |=> sta_reg[$past(sta_pos) +: 8] == $past(rdata_l)) else $error("address byte misplaced");
    load_done_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(loaded_reg) |-> $past(idx_reg) == MAC_BYTES && !busy_reg) else $error("early loaded flag");
    clk_count_a: assert property (@(posedge link_clk) disable iff (!nrst)
        $fell(pins_reg.cs) && en_s2 && $past(lstate_reg, 2) == LS_SHIFT && !$past(ab_s2, 2)
        |-> edge_cnt == nbits_reg) else $error("wrong clock count");
    start_bit_a: assert property (@(posedge link_clk) disable iff (!nrst)
        en_s2 && $rose(pins_reg.sclk) && edge_cnt == 5'h1 |-> pins_reg.dout && pins_reg.cs)
        else $error("start bit missing");
    gpio_mode_a: assert property (@(posedge link_clk) disable iff (!nrst)
        !en_s2 |=> pins_reg.sclk == $past(gp_s2[0]) && !pins_reg.oe_n) else $error("gpio not driven");
    poll_end_a: assert property (@(posedge link_clk) disable iff (!nrst)
        poll_ok && !ab_s2 |-> ##2 !pins_reg.cs) else $error("poll did not end");
endmodule : sec_ctrl

// ===== sec_pkg.sv
// shared constants, types and frame helpers for the serial rom controller
package sec_pkg;
    localparam int CLK_MHZ = 200;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int TMR_W = 23;
    localparam logic [7:0] SIG_BYTE = 8'ha5;
    localparam logic [6:0] SIG_ADDR = 7'h00;
    localparam logic [2:0] MAC_BYTES = 3'h6;
    localparam logic [4:0] BITS_SHORT = 5'h0a;
    localparam logic [4:0] BITS_LONG = 5'h12;
    localparam logic [4:0] BITS_HDR = 5'h0a;
    localparam logic [2:0] PH_LAST = 3'h7;
    localparam logic [2:0] PH_RISE = 3'h2;
    localparam logic [2:0] PH_FALL = 3'h6;
    // link cycles after reselect before the ready level on the data pin is trusted
    localparam logic [2:0] PH_SETTLE = 3'h3;
    localparam logic [2:0] CMD_READ = 3'h0;
    localparam logic [2:0] CMD_WR_DIS = 3'h1;
    localparam logic [2:0] CMD_WR_EN = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_WR_ALL = 3'h4;
    localparam logic [2:0] CMD_ERASE = 3'h5;
    localparam logic [2:0] CMD_ER_ALL = 3'h6;
    localparam logic [2:0] CMD_RELOAD = 3'h7;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [6:0] EXT_WR_DIS = 7'h00;
    localparam logic [6:0] EXT_WR_ALL = 7'h20;
    localparam logic [6:0] EXT_ER_ALL = 7'h40;
    localparam logic [6:0] EXT_WR_EN = 7'h60;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b11, ST_DRAIN = 2'b10} sec_core_e;
    typedef enum logic [1:0] {LS_IDLE = 2'b00, LS_SHIFT = 2'b01, LS_GAP = 2'b11, LS_POLL = 2'b10} sec_link_e;
    typedef struct packed {logic [2:0] code; logic [6:0] addr; logic [7:0] data;} sec_req_s;
    typedef struct packed {logic sclk; logic cs; logic dout; logic oe_n;} sec_pins_s;

    // start bit, opcode, address, data; short frames use the top ten bits
    function automatic logic [17:0] sec_frame(input sec_req_s r);
        logic [1:0] op;
        logic [6:0] a;
        op = OP_EXT;
        a = r.addr;
        case (r.code)
            CMD_READ: op = OP_READ;
            CMD_WRITE: op = OP_WRITE;
            CMD_ERASE: op = OP_ERASE;
            CMD_WR_DIS: a = EXT_WR_DIS;
            CMD_WR_EN: a = EXT_WR_EN;
            CMD_WR_ALL: a = EXT_WR_ALL;
            CMD_ER_ALL: a = EXT_ER_ALL;
            default: op = OP_EXT;
        endcase
        return {1'b1, op, a, r.data};
    endfunction : sec_frame

    function automatic logic sec_is_prog(input logic [2:0] c);
        return c == CMD_WRITE || c == CMD_WR_ALL || c == CMD_ERASE || c == CMD_ER_ALL;
    endfunction : sec_is_prog
endpackage : sec_pkg

// ===== sec_rom_model.sv
// behavioural three-wire serial rom, 128 bytes, for the controller bench
`timescale 1ns/10ps
module sec_rom_model (
    // rom pins
    input wire logic sclk,
    input wire logic cs,
    input wire logic din,
    output logic dout,
    // fault and pacing control from the bench
    input wire logic hang,
    input wire logic slow
);
    // ----------------------------------------
    // array and frame state
    // ----------------------------------------
    logic [7:0] mem [128];
    logic [17:0] sh = 18'h00000;
    logic [9:0] h;
    logic [7:0] rd;
    logic we = 1'b0;
    logic busy = 1'b0;
    logic rdm = 1'b0;
    logic pg;
    int n = 0;
    initial dout = 1'b1;
    // header and data sampled on rising clock
    always @(posedge sclk) if (cs) begin
        sh <= {sh[16:0], din};
        n <= n + 1;
    end
    // read data changes on the falling clock so it is stable through the bit
    always @(negedge sclk) begin
        if (n == 10) begin
            rdm = sh[9:7] == 3'b110;
            rd = mem[sh[6:0]];
        end
        if (rdm && n >= 10 && n < 18) dout = rd[17 - n];
    end
    // ready/busy status shown while selected without clocks
    always @(posedge cs or busy) if (cs && n == 0) dout = ~busy;
    // released line wanders so a stale level is never mistaken for data
    always #3 if (!(cs && (rdm || n == 0))) dout = ~dout;
    // ----------------------------------------
    // command execution at deselect
    // ----------------------------------------
    always @(negedge cs) begin
        h = (n == 18) ? sh[17:8] : sh[9:0];
        // enable opens erase and write until disabled
        if (n == 10 && h[8:5] == 4'b0011) we = 1'b1;
        // disable locks out erase and write
        if (n == 10 && h[8:5] == 4'b0000) we = 1'b0;
        pg = we && ((n == 18 && (h[8:7] == 2'b01 || h[8:5] == 4'b0001))
            || (n == 10 && (h[8:7] == 2'b11 || h[8:5] == 4'b0010)));
        if (pg && h[8:7] == 2'b01) mem[h[6:0]] = sh[7:0];
        if (pg && h[8:5] == 4'b0001) foreach (mem[i]) mem[i] = sh[7:0];
        if (pg && h[8:7] == 2'b11) mem[h[6:0]] = 8'hff;
        if (pg && h[8:5] == 4'b0010) foreach (mem[i]) mem[i] = 8'hff;
        if (pg) busy = 1'b1;
        if (pg && !hang) busy <= #(slow ? 12000 : 3000) 1'b0;
        n = 0;
        rdm = 1'b0;
    end
    always @(negedge hang) busy = 1'b0;
endmodule : sec_rom_model

// ===== testbench.sv
// self-checking bench for the serial rom controller
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench import sec_pkg::*;;
    typedef struct packed {logic rd; logic [7:0] clks; logic [7:0] data; logic to;} sec_exp_s;
    localparam logic [7:0] N_LONG = 8'h12;
    localparam logic [7:0] N_SHORT = 8'h0a;
    logic core_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, soft_reset = 1'b0, cmd_go = 1'b0;
    logic [2:0] command_code_field = 3'h0;
    logic [6:0] command_address_field = 7'h00;
    logic data_wr_en = 1'b0, timeout_clr = 1'b0, iface_en = 1'b1, hang = 1'b0, slow = 1'b0;
    logic [7:0] data_wr = 8'h00, pin_cnt = 8'h00, base = 8'h00, d;
    logic [1:0] gpio_out = 2'h0;
    logic command_busy_bit, response_timeout_bit, reload_success_bit, rom_dout;
    logic [7:0] serial_rom_data_reg;
    logic [47:0] station_address, sta;
    logic serial_rom_clock_pin, serial_rom_cs, serial_rom_data_pin_o, serial_rom_data_pin_oe_n;
    wire serial_rom_data_pin_i = serial_rom_data_pin_oe_n ? rom_dout : serial_rom_data_pin_o;
    logic [7:0] img [128];
    logic [6:0] a;
    sec_exp_s exp_q[$];
    sec_exp_s e;
    int miscompares = 0;
    int total_checks = 0;
    always #2.5 core_clk = ~core_clk;
    initial begin
        #1.3;
        forever #62.5 link_clk = ~link_clk;
    end
    sec_ctrl #(.TIMEOUT_CYCLES(10000)) u_sec_ctrl (.core_clk, .nrst, .link_clk, .soft_reset, .cmd_go,
        .command_code_field, .command_address_field, .data_wr_en, .data_wr, .timeout_clr, .iface_en,
        .gpio_out, .command_busy_bit, .response_timeout_bit, .reload_success_bit, .serial_rom_data_reg,
        .station_address, .serial_rom_clock_pin, .serial_rom_cs, .serial_rom_data_pin_o,
        .serial_rom_data_pin_oe_n, .serial_rom_data_pin_i);
    sec_rom_model u_sec_rom_model (.sclk(serial_rom_clock_pin), .cs(serial_rom_cs),
        .din(serial_rom_data_pin_i), .dout(rom_dout), .hang, .slow);
    // ----------------------------------------
    // result watcher and tasks
    // ----------------------------------------
    always @(posedge serial_rom_clock_pin) if (serial_rom_cs) pin_cnt++;
    always @(negedge command_busy_bit) begin
        #1;
        `CHK(exp_q.size() > 0, 1'b1)
        e = exp_q.pop_front();
        `CHK(8'(pin_cnt - base), e.clks)
        if (e.rd) `CHK(serial_rom_data_reg, e.data)
        `CHK(response_timeout_bit, e.to)
        base = pin_cnt;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic idle();
        int k;
        k = 0;
        while (command_busy_bit !== 1'b0) begin
            @(posedge core_clk);
            k++;
            if (k > 60000) begin
                miscompares++;
                print_verdict();
            end
        end
    endtask : idle
    task automatic put(input logic [7:0] v);
        data_wr <= v;
        data_wr_en <= 1'b1;
        @(posedge core_clk);
        data_wr_en <= 1'b0;
    endtask : put
    task automatic cmd(input logic [2:0] c, input logic [6:0] ad, input logic [7:0] n, input logic [7:0] v,
        input logic t);
        idle();
        exp_q.push_back({c == CMD_READ, n, v, t});
        command_code_field <= c;
        command_address_field <= ad;
        cmd_go <= 1'b1;
        @(posedge core_clk);
        cmd_go <= 1'b0;
        @(posedge core_clk);
        idle();
    endtask : cmd
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h966e));
        foreach (img[i]) img[i] = 8'($urandom);
        img[0] = SIG_BYTE;
        foreach (img[i]) u_sec_rom_model.mem[i] = img[i];
        sta = {img[6], img[5], img[4], img[3], img[2], img[1]};
        exp_q.push_back({1'b0, 8'h7e, 8'h00, 1'b0});
        repeat (5) @(posedge link_clk);
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        idle();
        `CHK(station_address, sta)
        `CHK(reload_success_bit, 1'b1)
        $display("test autoload done");
        for (int i = 1; i < 7; i++) begin
            img[i] = 8'($urandom);
            u_sec_rom_model.mem[i] = img[i];
        end
        sta = {img[6], img[5], img[4], img[3], img[2], img[1]};
        cmd(CMD_RELOAD, 7'h00, 8'h7e, 8'h00, 1'b0);
        `CHK(station_address, sta)
        `CHK(reload_success_bit, 1'b1)
        $display("test reload done");
        cmd(CMD_WR_EN, 7'h00, N_SHORT, 8'h00, 1'b0);
        d = 8'($urandom);
        put(d);
        cmd(CMD_WRITE, 7'h7f, N_LONG, 8'h00, 1'b0);
        cmd(CMD_READ, 7'h7f, N_LONG, d, 1'b0);
        cmd(CMD_ERASE, 7'h7f, N_SHORT, 8'h00, 1'b0);
        cmd(CMD_READ, 7'h7f, N_LONG, 8'hff, 1'b0);
        d = 8'($urandom);
        a = 7'($urandom_range(126));
        slow <= 1'b1;
        put(d);
        cmd(CMD_WR_ALL, 7'h00, N_LONG, 8'h00, 1'b0);
        slow <= 1'b0;
        cmd(CMD_READ, a, N_LONG, d, 1'b0);
        cmd(CMD_ER_ALL, 7'h00, N_SHORT, 8'h00, 1'b0);
        cmd(CMD_READ, a, N_LONG, 8'hff, 1'b0);
        cmd(CMD_WR_DIS, 7'h00, N_SHORT, 8'h00, 1'b0);
        $display("test program done");
        cmd(CMD_RELOAD, 7'h00, N_LONG, 8'h00, 1'b0);
        `CHK(reload_success_bit, 1'b0)
        exp_q.push_back({1'b0, N_LONG, 8'h00, 1'b0});
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        idle();
        `CHK(station_address, sta)
        `CHK(reload_success_bit, 1'b0)
        $display("test no signature done");
        cmd(CMD_WR_EN, 7'h00, N_SHORT, 8'h00, 1'b0);
        hang <= 1'b1;
        put(8'h3c);
        cmd(CMD_WRITE, 7'h10, N_LONG, 8'h00, 1'b1);
        hang <= 1'b0;
        timeout_clr <= 1'b1;
        @(posedge core_clk);
        timeout_clr <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK(response_timeout_bit, 1'b0)
        $display("test timeout done");
        iface_en <= 1'b0;
        for (int v = 0; v < 4; v++) begin
            gpio_out <= 2'(v);
            repeat (100) @(posedge core_clk);
            `CHK(serial_rom_clock_pin, gpio_out[0])
            `CHK(serial_rom_data_pin_o, gpio_out[1])
        end
        $display("test gpio done");
        print_verdict();
    end
    initial begin
        // about 550 us of traffic expected; some margin before calling it a hang
        #650000;
        miscompares++;
        print_verdict();
    end
endmodule : testbench
